// *** logic/exec_pkg.sv ***
package exec_pkg;
  // register map, byte offsets on the bus
  localparam logic [10:0] OFS_INSTR = 11'h000;
  localparam logic [10:0] OFS_OPND  = 11'h004;
  localparam logic [10:0] OFS_PC    = 11'h008;
  localparam logic [10:0] OFS_WP    = 11'h00C;
  localparam logic [10:0] OFS_ST    = 11'h010;
  localparam logic [10:0] OFS_STAT  = 11'h014;
  localparam int          MEM_SEL   = 10;
  localparam int          MEM_DEPTH = 256;
  localparam int          CODE_W    = 3;
  // opcodes
  localparam logic [9:0]  OP_B      = 10'h011;
  localparam logic [9:0]  OP_BL     = 10'h01A;
  localparam logic [9:0]  OP_CONTEXT_SWITCH_CALL   = 10'h010;
  localparam logic [5:0]  OP_XOP    = 6'h0B;
  localparam logic [7:0]  OP_JMP    = 8'h10;
  localparam logic [10:0] OP_IDLE   = 11'h01A;
  localparam logic [10:0] OP_IO_RESET_INSTR   = 11'h01B;
  localparam logic [10:0] OP_UC1    = 11'h01E;
  localparam logic [10:0] OP_UC2    = 11'h01D;
  localparam logic [10:0] OP_LOAD_REQUEST_INSTR   = 11'h01F;
  localparam logic [10:0] OP_CONTEXT_RETURN   = 11'h01C;
  localparam logic [10:0] OP_AI     = 11'h011;
  localparam logic [10:0] OP_AND_IMMEDIATE   = 11'h012;
  localparam logic [10:0] OP_CI     = 11'h014;
  localparam logic [10:0] OP_LI     = 11'h010;
  localparam logic [10:0] OP_ORI    = 11'h013;
  localparam logic [10:0] OP_WORKSPACE_LOAD_IMMEDIATE   = 11'h017;
  localparam logic [10:0] OP_MASK_LOAD_IMMEDIATE   = 11'h018;
  localparam logic [1:0]  TS_SYMB   = 2'h2;
  // control codes on the top address lines, A0 is the msb
  localparam logic [2:0]  CODE_IDLE = 3'h2;
  localparam logic [2:0]  CODE_IO_RESET_INSTR = 3'h3;
  localparam logic [2:0]  CODE_UC1  = 3'h6;
  localparam logic [2:0]  CODE_UC2  = 3'h5;
  localparam logic [2:0]  CODE_LOAD_REQUEST_INSTR = 3'h7;
  // workspace and vector layout
  localparam logic [15:0] R11_OFS   = 16'h0016;
  localparam logic [15:0] R13_OFS   = 16'h001A;
  localparam logic [15:0] R14_OFS   = 16'h001C;
  localparam logic [15:0] R15_OFS   = 16'h001E;
  localparam logic [15:0] XOP_BASE  = 16'h0040;
  localparam logic [15:0] PC_STEP1  = 16'h0002;
  localparam logic [15:0] PC_STEP2  = 16'h0004;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  // status bit positions, bit 0 of the word is stored at 15
  localparam int          SB_LGT    = 15;
  localparam int          SB_AGT    = 14;
  localparam int          SB_EQ     = 13;
  localparam int          SB_C      = 12;
  localparam int          SB_OV     = 11;
  localparam int          SB_XOP    = 9;
  localparam int          MASK_HI   = 3;
  localparam int          MASK_LO   = 0;
  localparam logic [3:0]  MASK_CLR  = 4'h0;
  localparam logic [1:0]  LREQ_DLY  = 2'h2;
  localparam logic [1:0]  LREQ_ONE  = 2'h1;

  typedef enum logic [2:0] {
    S_READY = 3'h0, S_EXEC = 3'h1, S_SAVE13 = 3'h3, S_SAVE14 = 3'h2,
    S_SAVE15 = 3'h6, S_SAVE11 = 3'h7, S_HALT = 3'h4
  } exec_state_t;
endpackage

// *** logic/branch_context_exec.sv ***
// Functional notes
// RQ1: context switch reads two-word vector at source: new workspace, then new pc
// RQ2: interrupt input is not sampled after a context switch or extended call
// RQ3: old workspace, pc and status saved to registers 13, 14, 15 of new workspace
// RQ4: return reloads workspace, pc and whole status from registers 13, 14, 15
// RQ5: relative jump is one word, signed 8-bit word displacement from pc
// RQ6: absolute branch loads pc with the source address
// RQ7: jump and link also writes the updated pc into register 11
// RQ8: extended call uses one of sixteen low vectors, source address to new r11
// RQ9: external instructions drive a three-bit code and pulse the io bus strobe
// RQ10: idle code 010 halts until interrupt, load request or reset
// RQ11: io reset code 011 clears the interrupt mask in status bits 12 to 15
// RQ12: user codes 110 and 101 are driven for outside decoding
// RQ13: load request code 111 raises a load interrupt two fetches later
// RQ14: return drives no code and gives no strobe
// RQ15: immediate add, and, compare, load, or; add sets status 0-4, others 0-2
// RQ16: workspace load copies the immediate word, status untouched
// RQ17: mask load copies immediate bits 12-15 into status bits 12-15
// RQ18: branch, link and context call decoded from ten-bit opcodes
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module branch_context_exec (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [31:0]                      hrdata,
  output logic                             hresp,
  // pins
  input  wire logic                        interrupt_request_n,
  input  wire logic                        load_request_n,
  output logic [exec_pkg::CODE_W-1:0]      addr_code,
  output logic                             io_bus_strobe,
  output logic                             instruction_fetch_flag,
  output logic                             load_interrupt,
  output logic                             halted
);
  import exec_pkg::*;

  exec_state_t state, next_state;
  logic [15:0] pc, wp, st, instr, opnd, ctx_wp, ctx_pc, ctx_st;
  logic [15:0] next_pc, next_wp, next_st, next_instr, next_opnd;
  logic [15:0] next_ctx_wp, next_ctx_pc, next_ctx_st;
  logic        ctx_xop, next_ctx_xop, int_taken, next_int_taken;
  logic [2:0]  next_addr_code;
  logic        next_strobe, next_iaq, next_load_int, next_halted;
  logic [1:0]  lreq_cnt, next_lreq_cnt;
  logic [1:0]  pin_meta, pin_sync;
  logic        dph_wr, next_dph_wr, next_hreadyout, next_hresp;
  logic [10:0] dph_addr, next_dph_addr;
  logic [31:0] next_hrdata;
  logic [15:0] mem [MEM_DEPTH];
  logic        mem_we;
  logic [7:0]  mem_wa;
  logic [15:0] mem_wd;

  // byte address to memory word index
  function automatic logic [7:0] widx(input logic [15:0] a);
    return a[8:1];
  endfunction

  // external code of an opcode, msb flags a control instruction
  function automatic logic [3:0] ext_of(input logic [10:0] op);
    case (op)
      OP_IDLE: return {1'b1, CODE_IDLE};
      OP_IO_RESET_INSTR: return {1'b1, CODE_IO_RESET_INSTR};
      OP_UC1:  return {1'b1, CODE_UC1};
      OP_UC2:  return {1'b1, CODE_UC2};
      OP_LOAD_REQUEST_INSTR: return {1'b1, CODE_LOAD_REQUEST_INSTR};
      default: return {1'b0, CODE_IDLE};
    endcase
  endfunction

  // pin synchronisers, bit 0 interrupt, bit 1 load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      pin_meta <= {load_request_n, interrupt_request_n};
      pin_sync <= pin_meta;
    end
  end

  // decode
  logic [9:0]  op10;
  logic [10:0] op11;
  logic        ex, is_b, is_bl, is_context_switch_call, is_xop, is_jmp, is_context_return, is_ext, is_imm;
  logic        is_ci, two_word;
  logic [3:0]  ext;
  logic [15:0] upd_pc, jmp_tgt, vec_addr, vec_wp, vec_pc, rd13, rd14, rd15, rval, res;
  logic [7:0]  ridx;
  logic [16:0] sum;
  assign op10     = instr[15:6];
  assign op11     = instr[15:5];
  assign ex       = state == S_EXEC;
  // RQ18 ten-bit opcode decode
  assign is_b     = op10 == OP_B;
  assign is_bl    = op10 == OP_BL;
  assign is_context_switch_call  = op10 == OP_CONTEXT_SWITCH_CALL;
  assign is_xop   = instr[15:10] == OP_XOP;
  assign is_jmp   = instr[15:8] == OP_JMP;
  assign is_context_return  = op11 == OP_CONTEXT_RETURN;
  assign ext      = ext_of(op11);
  assign is_ext   = ext[3];
  assign is_ci    = op11 == OP_CI;
  assign is_imm   = is_ci || op11 == OP_AI || op11 == OP_AND_IMMEDIATE || op11 == OP_LI
                    || op11 == OP_ORI;
  assign two_word = is_imm || op11 == OP_WORKSPACE_LOAD_IMMEDIATE || op11 == OP_MASK_LOAD_IMMEDIATE
                    || ((is_b || is_bl || is_context_switch_call || is_xop) && instr[5:4] == TS_SYMB);
  assign upd_pc   = pc + (two_word ? PC_STEP2 : PC_STEP1);
  // RQ5 signed word displacement
  assign jmp_tgt  = upd_pc + {{7{instr[7]}}, instr[7:0], 1'b0};
  // RQ8 vector slot from the call number
  assign vec_addr = is_xop ? XOP_BASE + {10'h000, instr[9:6], 2'h0} : opnd;
  assign vec_wp   = mem[widx(vec_addr)];
  assign vec_pc   = mem[widx(vec_addr + PC_STEP1)];
  assign rd13     = mem[widx(wp + R13_OFS)];
  assign rd14     = mem[widx(wp + R14_OFS)];
  assign rd15     = mem[widx(wp + R15_OFS)];
  assign ridx     = widx(wp + {11'h000, instr[3:0], 1'b0});
  assign rval     = mem[ridx];
  assign sum      = {1'b0, rval} + {1'b0, opnd};
  assign res      = op11 == OP_AI ? sum[15:0] : op11 == OP_AND_IMMEDIATE ? (rval & opnd)
                  : op11 == OP_ORI ? (rval | opnd) : opnd;

  // workspace memory
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // execution next state
  always_comb begin
    next_state     = state;
    next_pc        = pc;
    next_wp        = wp;
    next_st        = st;
    next_instr     = instr;
    next_opnd      = opnd;
    next_ctx_wp    = ctx_wp;
    next_ctx_pc    = ctx_pc;
    next_ctx_st    = ctx_st;
    next_ctx_xop   = ctx_xop;
    next_int_taken = int_taken;
    next_addr_code = addr_code;
    next_strobe    = 1'b0;
    next_iaq       = 1'b0;
    next_load_int  = 1'b0;
    next_lreq_cnt  = lreq_cnt;
    mem_we         = 1'b0;
    mem_wa         = dph_addr[9:2];
    mem_wd         = hwdata[15:0];
    case (state)
      S_READY: begin
        if (dph_wr && dph_addr[MEM_SEL]) begin
          mem_we = 1'b1;
        end else if (dph_wr) begin
          case (dph_addr)
            OFS_INSTR: begin
              next_instr = hwdata[15:0];
              next_state = S_EXEC;
              next_iaq   = 1'b1;
              // RQ13 count fetches after arming
              if (lreq_cnt != 2'h0) begin
                next_lreq_cnt = lreq_cnt - LREQ_ONE;
                next_load_int = lreq_cnt == LREQ_ONE;
              end
            end
            OFS_OPND: next_opnd = hwdata[15:0];
            OFS_PC:   next_pc = hwdata[15:0];
            OFS_WP:   next_wp = hwdata[15:0];
            OFS_ST:   next_st = hwdata[15:0];
            default:  ;
          endcase
        end
      end
      S_EXEC: begin
        next_state     = S_READY;
        next_pc        = upd_pc;
        next_int_taken = !pin_sync[0];
        if (is_jmp) begin
          next_pc = jmp_tgt;
        end else if (is_b) begin
          // RQ6 absolute branch
          next_pc = opnd;
        end else if (is_bl) begin
          // RQ7 link into r11
          next_pc = opnd;
          mem_we  = 1'b1;
          mem_wa  = widx(wp + R11_OFS);
          mem_wd  = upd_pc;
        end else if (is_context_switch_call || is_xop) begin
          // RQ1 RQ8 load vector, keep old context
          next_wp        = vec_wp;
          next_pc        = vec_pc;
          next_ctx_wp    = wp;
          next_ctx_pc    = upd_pc;
          next_ctx_st    = st;
          next_ctx_xop   = is_xop;
          next_st[SB_XOP] = is_xop ? 1'b1 : st[SB_XOP];
          // RQ2 interrupt not sampled
          next_int_taken = int_taken;
          next_state     = S_SAVE13;
        end else if (is_context_return) begin
          // RQ4 RQ14 restore, no code, no strobe
          next_wp = rd13;
          next_pc = rd14;
          next_st = rd15;
        end else if (is_ext) begin
          // RQ9 RQ12 drive code and strobe
          next_addr_code = ext[2:0];
          next_strobe    = 1'b1;
          // RQ10 halt on idle
          if (op11 == OP_IDLE) begin
            next_state = S_HALT;
          end
          // RQ11 clear interrupt mask
          if (op11 == OP_IO_RESET_INSTR) begin
            next_st[MASK_HI:MASK_LO] = MASK_CLR;
          end
          // RQ13 arm load interrupt
          if (op11 == OP_LOAD_REQUEST_INSTR) begin
            next_lreq_cnt = LREQ_DLY;
          end
        end else if (is_imm) begin
          // RQ15 immediate ops and status
          next_st[SB_LGT] = is_ci ? rval > opnd : res != RST_WORD;
          next_st[SB_AGT] = is_ci ? $signed(rval) > $signed(opnd)
                                  : !res[15] && res != RST_WORD;
          next_st[SB_EQ]  = is_ci ? rval == opnd : res == RST_WORD;
          if (op11 == OP_AI) begin
            next_st[SB_C]  = sum[16];
            next_st[SB_OV] = rval[15] == opnd[15] && res[15] != rval[15];
          end
          mem_we = !is_ci;
          mem_wa = ridx;
          mem_wd = res;
        end else if (op11 == OP_WORKSPACE_LOAD_IMMEDIATE) begin
          // RQ16 workspace load
          next_wp = opnd;
        end else if (op11 == OP_MASK_LOAD_IMMEDIATE) begin
          // RQ17 mask load
          next_st[MASK_HI:MASK_LO] = opnd[MASK_HI:MASK_LO];
        end
      end
      // RQ3 save old context into new workspace
      S_SAVE13: begin
        mem_we     = 1'b1;
        mem_wa     = widx(wp + R13_OFS);
        mem_wd     = ctx_wp;
        next_state = S_SAVE14;
      end
      S_SAVE14: begin
        mem_we     = 1'b1;
        mem_wa     = widx(wp + R14_OFS);
        mem_wd     = ctx_pc;
        next_state = S_SAVE15;
      end
      S_SAVE15: begin
        mem_we     = 1'b1;
        mem_wa     = widx(wp + R15_OFS);
        mem_wd     = ctx_st;
        next_state = ctx_xop ? S_SAVE11 : S_READY;
      end
      // RQ8 parameter address into new r11
      S_SAVE11: begin
        mem_we     = 1'b1;
        mem_wa     = widx(wp + R11_OFS);
        mem_wd     = opnd;
        next_state = S_READY;
      end
      // RQ10 wake on interrupt or load
      S_HALT: begin
        if (!pin_sync[0] || !pin_sync[1]) begin
          next_state = S_READY;
        end
      end
      default: next_state = S_READY;
    endcase
    next_halted = next_state == S_HALT;
  end

  // execution registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                  <= S_READY;
      pc                     <= RST_WORD;
      wp                     <= RST_WORD;
      st                     <= RST_WORD;
      instr                  <= RST_WORD;
      opnd                   <= RST_WORD;
      ctx_wp                 <= RST_WORD;
      ctx_pc                 <= RST_WORD;
      ctx_st                 <= RST_WORD;
      ctx_xop                <= 1'b0;
      int_taken              <= 1'b0;
      addr_code              <= CODE_IDLE;
      io_bus_strobe          <= 1'b0;
      instruction_fetch_flag <= 1'b0;
      load_interrupt         <= 1'b0;
      lreq_cnt               <= 2'h0;
      halted                 <= 1'b0;
    end else begin
      state                  <= next_state;
      pc                     <= next_pc;
      wp                     <= next_wp;
      st                     <= next_st;
      instr                  <= next_instr;
      opnd                   <= next_opnd;
      ctx_wp                 <= next_ctx_wp;
      ctx_pc                 <= next_ctx_pc;
      ctx_st                 <= next_ctx_st;
      ctx_xop                <= next_ctx_xop;
      int_taken              <= next_int_taken;
      addr_code              <= next_addr_code;
      io_bus_strobe          <= next_strobe;
      instruction_fetch_flag <= next_iaq;
      load_interrupt         <= next_load_int;
      lreq_cnt               <= next_lreq_cnt;
      halted                 <= next_halted;
    end
  end

  // bus address phase capture and read mux
  always_comb begin
    next_dph_wr    = hsel && htrans[1] && hready && hwrite;
    next_dph_addr  = haddr[10:0];
    next_hrdata    = hrdata;
    next_hreadyout = 1'b1;
    next_hresp     = 1'b0;
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      if (haddr[MEM_SEL]) begin
        next_hrdata[15:0] = mem[haddr[9:2]];
      end else begin
        case (haddr[10:0])
          OFS_INSTR: next_hrdata[15:0] = instr;
          OFS_OPND:  next_hrdata[15:0] = opnd;
          OFS_PC:    next_hrdata[15:0] = pc;
          OFS_WP:    next_hrdata[15:0] = wp;
          OFS_ST:    next_hrdata[15:0] = st;
          OFS_STAT:  next_hrdata[3:0] = {lreq_cnt != 2'h0, int_taken, halted,
                                         state != S_READY};
          default:   ;
        endcase
      end
    end
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr    <= 1'b0;
      dph_addr  <= 11'h000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dph_wr    <= next_dph_wr;
      dph_addr  <= next_dph_addr;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_vec; ex && is_context_switch_call |=> wp == $past(vec_wp) && pc == $past(vec_pc); endproperty
  a_vec: assert property (p_vec) else $error("vector not loaded"); // RQ1
  property p_noint; ex && (is_context_switch_call || is_xop) |=> $stable(int_taken) [*4]; endproperty
  a_noint: assert property (p_noint) else $error("interrupt sampled"); // RQ2
  property p_save;
    state == S_SAVE13 |-> mem_we && mem_wd == ctx_wp ##1 mem_wd == ctx_pc
      ##1 mem_wd == ctx_st && mem_wa == widx(wp + R15_OFS);
  endproperty
  a_save: assert property (p_save) else $error("context save wrong"); // RQ3
  property p_ret; ex && is_context_return |=> wp == $past(rd13) && pc == $past(rd14)
    && st == $past(rd15); endproperty
  a_ret: assert property (p_ret) else $error("return wrong"); // RQ4
  property p_jmp; ex && is_jmp |=> pc == $past(jmp_tgt) && $past(upd_pc) == $past(pc)
    + PC_STEP1; endproperty
  a_jmp: assert property (p_jmp) else $error("jump wrong"); // RQ5
  property p_br; ex && (is_b || is_bl) |=> pc == $past(opnd); endproperty
  a_br: assert property (p_br) else $error("branch wrong"); // RQ6
  property p_link; ex && is_bl |-> mem_we && mem_wd == upd_pc
    && mem_wa == widx(wp + R11_OFS); endproperty
  a_link: assert property (p_link) else $error("link wrong"); // RQ7
  property p_xop; ex && is_xop |=> st[SB_XOP] ##3 mem_we && mem_wd == opnd; endproperty
  a_xop: assert property (p_xop) else $error("extended call wrong"); // RQ8
  property p_strobe; ex && is_ext |=> io_bus_strobe && addr_code == $past(ext[2:0])
    ##1 !io_bus_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong"); // RQ9
  property p_idle; ex && op11 == OP_IDLE |=> halted; endproperty
  a_idle: assert property (p_idle) else $error("idle not halted"); // RQ10
  property p_io_reset_instr; ex && op11 == OP_IO_RESET_INSTR |=> st[MASK_HI:MASK_LO] == MASK_CLR; endproperty
  a_io_reset_instr: assert property (p_io_reset_instr) else $error("mask not cleared"); // RQ11
  property p_rtq; ex && is_context_return |=> !io_bus_strobe && $stable(addr_code); endproperty
  a_rtq: assert property (p_rtq) else $error("return drove code"); // RQ14
  property p_workspace_load_immediate; ex && op11 == OP_WORKSPACE_LOAD_IMMEDIATE |=> wp == $past(opnd) && $stable(st); endproperty
  a_workspace_load_immediate: assert property (p_workspace_load_immediate) else $error("workspace load wrong"); // RQ16
  property p_mask_load_immediate; ex && op11 == OP_MASK_LOAD_IMMEDIATE |=> st[MASK_HI:MASK_LO] == $past(opnd[3:0]);
  endproperty
  a_mask_load_immediate: assert property (p_mask_load_immediate) else $error("mask load wrong"); // RQ17
  c_xop: cover property (state == S_SAVE11);
  c_load: cover property (load_interrupt);
  c_wake: cover property (halted ##1 !halted);
  c_uc2: cover property (io_bus_strobe && addr_code == CODE_UC2);
endmodule // branch_context_exec

// *** dv/ctrl_decode_model.sv ***
`timescale 1ns/1ps
// far-side decoder of the three-line control code
module ctrl_decode_model (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control code from the block
  input  wire logic       io_bus_strobe,
  input  wire logic [2:0] addr_code,
  // decoded view
  output logic [2:0]      last_code,
  output logic [7:0]      pulses
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_code <= 3'h0;
      pulses    <= 8'h00;
    end else if (io_bus_strobe) begin
      last_code <= addr_code;
      pulses    <= pulses + 8'h01;
    end
  end
endmodule // ctrl_decode_model

// *** dv/branch_context_control_exec_bench.sv ***
`timescale 1ns/1ps
module branch_context_control_exec_bench;
  import exec_pkg::*;
  typedef struct packed {logic [15:0] ins, opd, pc0, pc; logic [3:0] code;} row_t;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        interrupt_request_n = 1'b1, load_request_n = 1'b1;
  logic        hreadyout, hresp, io_bus_strobe, instruction_fetch_flag;
  logic        load_interrupt, halted;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, addr_code, last_code;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [7:0]  pulses, p0;
  int          miscompares = 0, checks = 0, cycles = 0, fetches = 0, li_at = -1, f0;
  // plain cases: word, operand, start pc, end pc, code (8 = none)
  row_t        rows [7] = '{
    '{16'h0460, 16'h1234, 16'h0100, 16'h1234, 4'h8},
    '{16'h107F, 16'h0000, 16'h0100, 16'h0200, 4'h8},
    '{16'h1080, 16'h0000, 16'h0300, 16'h0202, 4'h8},
    '{16'h03C0, 16'h0000, 16'h0100, 16'h0102, 4'h6},
    '{16'h03A0, 16'h0000, 16'h0100, 16'h0102, 4'h5},
    '{16'h0360, 16'h0000, 16'h0100, 16'h0102, 4'h3},
    '{16'h03E0, 16'h0000, 16'h0100, 16'h0102, 4'h7}};

  branch_context_exec branch_context_exec_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .interrupt_request_n(interrupt_request_n), .load_request_n(load_request_n),
    .addr_code(addr_code), .io_bus_strobe(io_bus_strobe),
    .instruction_fetch_flag(instruction_fetch_flag), .load_interrupt(load_interrupt),
    .halted(halted));
  ctrl_decode_model ctrl_decode_model_inst (
    .hclk(hclk), .hresetn(hresetn), .io_bus_strobe(io_bus_strobe),
    .addr_code(addr_code), .last_code(last_code), .pulses(pulses));

  // clock
  always #10 hclk = ~hclk;

  // cycle ceiling, fetch count and load interrupt position
  always @(posedge hclk) begin
    cycles++;
    if (load_interrupt) li_at = fetches;
    if (instruction_fetch_flag) fetches++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // one bus transfer, address phase then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_pin(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic rdchk(input string n, input logic [31:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(n, {16'h0000, e}, rd);
  endtask

  // processor byte address to bus address of the memory window
  function automatic logic [31:0] ma(input logic [15:0] x);
    return 32'h400 + {15'h0, x, 1'b0};
  endfunction

  // run one instruction and wait for busy to drop
  task automatic exec(input logic [15:0] i, input logic [15:0] o);
    int n;
    wr(32'(OFS_OPND), o);
    wr(32'(OFS_INSTR), i);
    n = 0;
    do begin
      bus(1'b0, 32'(OFS_STAT), 16'h0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    chk("addr_code", 32'h2, 32'(addr_code));
    chk_pin("halted", 1'b0, halted);
    chk_pin("hresp", 1'b0, hresp);
    chk_pin("hreadyout", 1'b1, hreadyout);
    hresetn <= 1'b1;
    rdchk("pc", 32'(OFS_PC), 16'h0000);
    rdchk("unmapped", 32'h018, 16'h0000);
    chk_pin("hresp", 1'b0, hresp);
    $display("reset test done");
    foreach (rows[k]) begin
      p0 = pulses;
      wr(32'(OFS_PC), rows[k].pc0);
      exec(rows[k].ins, rows[k].opd);
      rdchk("pc", 32'(OFS_PC), rows[k].pc);
      chk("strobes", 32'(rows[k].code[3] ? p0 : p0 + 8'h01), 32'(pulses));
      if (!rows[k].code[3]) chk("code", 32'(rows[k].code[2:0]), 32'(last_code));
    end
    f0 = fetches;
    $display("table test done");
    // context switch and return
    wr(32'(OFS_WP), 16'h0080);
    exec(16'h0202, 16'h0001);
    bus(1'b0, 32'(OFS_STAT), 16'h0000);
    chk_pin("int_taken", 1'b0, rd[2]);
    wr(32'(OFS_ST), 16'h0005);
    wr(32'(OFS_PC), 16'h0100);
    wr(ma(16'h00C0), 16'h0100);
    wr(ma(16'h00C2), 16'h0456);
    interrupt_request_n <= 1'b0;
    p0 = pulses;
    exec(16'h0420, 16'h00C0);
    chk("load_int_fetch", 32'(f0 + 1), 32'(li_at));
    rdchk("wp", 32'(OFS_WP), 16'h0100);
    rdchk("pc", 32'(OFS_PC), 16'h0456);
    rdchk("r13", ma(16'h011A), 16'h0080);
    rdchk("r14", ma(16'h011C), 16'h0104);
    rdchk("r15", ma(16'h011E), 16'h0005);
    bus(1'b0, 32'(OFS_STAT), 16'h0000);
    chk_pin("int_taken", 1'b0, rd[2]);
    exec(16'h0380, 16'h0000);
    interrupt_request_n <= 1'b1;
    rdchk("wp", 32'(OFS_WP), 16'h0080);
    rdchk("pc", 32'(OFS_PC), 16'h0104);
    rdchk("st", 32'(OFS_ST), 16'h0005);
    chk("strobes", 32'(p0), 32'(pulses));
    // extended call through vector 2
    wr(ma(16'h0048), 16'h0100);
    wr(ma(16'h004A), 16'h0200);
    exec(16'h2CA0, 16'h0077);
    rdchk("wp", 32'(OFS_WP), 16'h0100);
    rdchk("pc", 32'(OFS_PC), 16'h0200);
    rdchk("r11", ma(16'h0116), 16'h0077);
    rdchk("r13", ma(16'h011A), 16'h0080);
    // jump and link
    wr(32'(OFS_WP), 16'h0080);
    wr(32'(OFS_PC), 16'h0100);
    exec(16'h06A0, 16'h0300);
    rdchk("pc", 32'(OFS_PC), 16'h0300);
    rdchk("r11", ma(16'h0096), 16'h0104);
    $display("context test done");
    // immediates on register 2, then workspace load, mask load and io reset
    wr(ma(16'h0084), 16'h000F);
    exec(16'h0222, 16'h00FF);
    rdchk("r2", ma(16'h0084), 16'h010E);
    bus(1'b0, 32'(OFS_ST), 16'h0000);
    chk("st_add", 32'h18, 32'(rd[15:11]));
    exec(16'h0282, 16'h010E);
    bus(1'b0, 32'(OFS_ST), 16'h0000);
    chk("st_cmp", 32'h1, 32'(rd[15:13]));
    rdchk("r2", ma(16'h0084), 16'h010E);
    exec(16'h0242, 16'h00FF);
    rdchk("r2", ma(16'h0084), 16'h000E);
    exec(16'h0262, 16'hF000);
    rdchk("r2", ma(16'h0084), 16'hF00E);
    wr(32'(OFS_ST), 16'h000A);
    exec(16'h02E0, 16'h0090);
    rdchk("wp", 32'(OFS_WP), 16'h0090);
    rdchk("st", 32'(OFS_ST), 16'h000A);
    exec(16'h0300, 16'hFFF3);
    rdchk("st", 32'(OFS_ST), 16'h0003);
    exec(16'h0360, 16'h0000);
    rdchk("st", 32'(OFS_ST), 16'h0000);
    $display("immediate test done");
    // idle woken by each pin in turn
    for (int k = 0; k < 2; k++) begin
      exec(16'h0340, 16'h0000);
      chk_pin("halted", 1'b1, halted);
      chk("addr_code", 32'h2, 32'(addr_code));
      if (k == 0) interrupt_request_n <= 1'b0;
      else load_request_n <= 1'b0;
      for (int n = 0; n < 10 && halted !== 1'b0; n++) @(posedge hclk);
      chk_pin("halted", 1'b0, halted);
      interrupt_request_n <= 1'b1;
      load_request_n <= 1'b1;
    end
    $display("idle test done");
    finish_test();
  end
endmodule // branch_context_control_exec_bench
